// *** injection_rx.sv ***
// receiver end: samples the injection link and writes words to memory or, when select picks it, the config port
// Operation
// (RULE1) bus controller writes anywhere in 32-bit space
// (RULE2) trace packets carry address then data
// (RULE3) direct mode writes consecutive self-made addresses
// (RULE4) lane width 1, 2, 4, 8, 16
// (RULE5) at most 100 Mbit/s per pin
// (RULE6) data sampled on link clock falling edge
// (RULE7) sync sampled on falling edge, marks packet
// (RULE8) select pin steers data or config path
// (RULE9) beats assemble whole words, order kept
`timescale 1ns/1ps
module injection_rx (
   input  wire logic                               i_clk,
   input  wire logic                               i_rst_b,
   input  wire logic                               i_trace_mode,
   input  wire injection_pkg::width_code_t         i_width_code,
   input  wire logic [injection_pkg::ADDR_W-1:0]   i_direct_base,
   injection_if.rx                                 link,
   output logic                                    o_bus_req,
   output logic [injection_pkg::ADDR_W-1:0]        o_bus_addr,
   output logic [injection_pkg::WORD_W-1:0]        o_bus_data,
   input  wire logic                               i_bus_ack,
   output logic                                    o_cfg_valid,
   output logic [injection_pkg::ADDR_W-1:0]        o_cfg_addr,
   output logic [injection_pkg::WORD_W-1:0]        o_cfg_word,
   output logic                                    o_overrun
);

   // sampling needs the fastest link period to span at least one local clock
   if (injection_pkg::LINK_MIN_NS < injection_pkg::CLK_PERIOD_NS) begin : g_rate_chk // RULE5
      $error("link rate above what the sampler can follow");
   end

   // two-stage synchronisers for every link input
   logic [1:0]                      clk_sync;
   logic [1:0]                      sync_sync;
   logic [1:0]                      sel_sync;
   logic [injection_pkg::LANES-1:0] data_s1;
   logic [injection_pkg::LANES-1:0] data_s2;
   logic                            clk_prev;

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         clk_sync  <= 2'h3;
         sync_sync <= 2'h0;
         sel_sync  <= 2'h0;
         data_s1   <= '0;
         data_s2   <= '0;
         clk_prev  <= 1'b1;
      end else begin
         clk_sync  <= {clk_sync[0], link.link_clk};
         sync_sync <= {sync_sync[0], link.link_sync};
         sel_sync  <= {sel_sync[0], link.injection_path_select};
         data_s1   <= link.link_data;
         data_s2   <= data_s1;
         clk_prev  <= clk_sync[1];
      end
   end

   // falling edge seen after the synchronisers; data and sync share the same delay
   wire fall     = clk_prev & ~clk_sync[1]; // RULE6
   wire sync_now = sync_sync[1];            // RULE7
   wire to_cfg   = sel_sync[1];             // RULE8

   // lane geometry from the width code
   wire [5:0]  lane_bits = 6'(6'h01 << i_width_code);                                  // RULE4
   wire [4:0]  beats_m1  = 5'((injection_pkg::WORD_BITS >> i_width_code) - 6'h01);     // RULE4
   wire [15:0] lane_mask = 16'((32'h1 << lane_bits) - 32'h1);                          // RULE4
   wire [15:0] lane_val  = data_s2 & lane_mask;                                        // RULE4

   // assembly state
   logic [injection_pkg::WORD_W-1:0] asm_word;
   logic [4:0]                       beat;
   injection_pkg::phase_t            phase;
   logic [injection_pkg::ADDR_W-1:0] trace_addr;
   logic [injection_pkg::ADDR_W-1:0] dir_addr;

   // first beat lands lowest once the word is complete
   wire [5:0]  fill_shift = 6'(injection_pkg::WORD_BITS - lane_bits);
   wire [31:0] next_word  = (asm_word >> lane_bits) | (32'(lane_val) << fill_shift); // RULE9
   wire [4:0]  cur_beat   = sync_now ? 5'h00 : beat;                                  // RULE7
   wire        word_done  = fall & (cur_beat == beats_m1);                            // RULE9

   // a sync beat restarts the packet
   wire injection_pkg::phase_t cur_phase = sync_now ? injection_pkg::PH_ADDR : phase;
   wire [31:0] cur_dir   = sync_now ? i_direct_base : dir_addr;                       // RULE3
   wire        addr_word = i_trace_mode & (cur_phase == injection_pkg::PH_ADDR);      // RULE2
   wire        issue     = word_done & ~addr_word;
   wire [31:0] wr_addr   = i_trace_mode ? trace_addr : cur_dir;                       // RULE2
   wire        bus_busy  = o_bus_req & ~i_bus_ack;

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         asm_word <= '0;
         beat     <= 5'h00;
      end else if (fall) begin
         asm_word <= next_word; // RULE9
         beat     <= word_done ? 5'h00 : 5'(cur_beat + 5'h01);
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         phase      <= injection_pkg::PH_ADDR;
         trace_addr <= '0;
         dir_addr   <= '0;
      end else if (fall) begin
         phase    <= cur_phase;
         dir_addr <= cur_dir;
         if (word_done) begin
            if (addr_word) begin
               trace_addr <= next_word; // RULE2
               phase      <= injection_pkg::PH_DATA;
            end else begin
               phase    <= injection_pkg::PH_ADDR;
               // wraps at the top of the 32-bit space
               dir_addr <= i_trace_mode ? cur_dir : cur_dir + injection_pkg::ADDR_STEP; // RULE3
            end
         end
      end
   end

   // bus write port: one outstanding write, held until acknowledged
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_bus_req  <= 1'b0;
         o_bus_addr <= '0;
         o_bus_data <= '0;
         o_overrun  <= 1'b0;
      end else begin
         if (issue && !to_cfg) begin
            if (bus_busy) begin
               // no buffer: a word that finds the bus still busy is dropped and flagged
               o_overrun <= 1'b1;
            end else begin
               o_bus_req  <= 1'b1;       // RULE1
               o_bus_addr <= wr_addr;    // RULE1
               o_bus_data <= next_word;  // RULE9
            end
         end else if (i_bus_ack) begin
            o_bus_req <= 1'b0;
         end
      end
   end

   // configuration path: one-cycle strobe per word
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_cfg_valid <= 1'b0;
         o_cfg_addr  <= '0;
         o_cfg_word  <= '0;
      end else begin
         o_cfg_valid <= issue & to_cfg; // RULE8
         if (issue && to_cfg) begin
            o_cfg_addr <= wr_addr;
            o_cfg_word <= next_word;
         end
      end
   end

endmodule

// *** injection_pkg.sv ***
// shared constants and types for the external data injection link
package injection_pkg;
   localparam int          CLK_PERIOD_NS  = 10;
   localparam int          PIN_RATE_MBPS  = 100;
   localparam int          LINK_MIN_NS    = 1000 / PIN_RATE_MBPS;
   localparam int          LINK_PERIOD_NS = 80;
   localparam int          LANES          = 16;
   localparam int          WORD_W         = 32;
   localparam int          ADDR_W         = 32;
   localparam logic [5:0]  WORD_BITS      = 6'h20;
   localparam logic [31:0] ADDR_STEP      = 32'h0000_0004;
   localparam logic [2:0]  WIDTH_MAX_CODE = 3'h4;

   // lane width code: lanes = 1 << code
   typedef logic [2:0] width_code_t;
   localparam width_code_t WIDTH_1  = 3'h0;
   localparam width_code_t WIDTH_2  = 3'h1;
   localparam width_code_t WIDTH_4  = 3'h2;
   localparam width_code_t WIDTH_8  = 3'h3;
   localparam width_code_t WIDTH_16 = 3'h4;

   typedef enum logic [1:0] {
      PH_ADDR = 2'b01,
      PH_DATA = 2'b10
   } phase_t;
endpackage

// *** injection_if.sv ***
// link wires between the external source and the injection receiver
`timescale 1ns/1ps
interface injection_if;
   logic                             link_clk;
   logic                             link_sync;
   logic [injection_pkg::LANES-1:0]  link_data;
   logic                             injection_path_select;

   modport src (
      output link_clk,
      output link_sync,
      output link_data,
      output injection_path_select
   );

   modport rx (
      input link_clk,
      input link_sync,
      input link_data,
      input injection_path_select
   );
endinterface

// *** injection_src.sv ***
// source end: makes the link clock and streams words over the lanes
`timescale 1ns/1ps
module injection_src #(
   parameter int DIV = injection_pkg::LINK_PERIOD_NS / injection_pkg::CLK_PERIOD_NS
) (
   input  wire logic                               i_clk,
   input  wire logic                               i_rst_b,
   input  wire injection_pkg::width_code_t         i_width_code,
   input  wire logic                               i_path_select,
   input  wire logic                               i_word_valid,
   input  wire logic                               i_word_first,
   input  wire logic [injection_pkg::WORD_W-1:0]   i_word,
   output logic                                    o_word_taken,
   output logic                                    o_busy,
   injection_if.src                                link
);

   // per-pin rate limit and an even divider with room for the far sampler
   if (DIV < 4 || (DIV % 2) != 0 ||
       DIV * injection_pkg::CLK_PERIOD_NS < injection_pkg::LINK_MIN_NS) begin : g_div_chk
      $error("link divider must be even, at least 4, and within the pin rate"); // RULE5
   end

   localparam logic [7:0] HALF_M1 = 8'(DIV / 2 - 1);
   localparam logic [7:0] DIV_M1  = 8'(DIV - 1);

   logic [7:0]  cnt;
   logic [4:0]  beat;
   logic [31:0] shreg;
   logic        lclk;
   logic        lsync;
   logic [15:0] ldata;
   logic        lsel;

   wire [5:0]  lane_bits = 6'(6'h01 << i_width_code);                              // RULE4
   wire [4:0]  beats_m1  = 5'((injection_pkg::WORD_BITS >> i_width_code) - 6'h01); // RULE4
   wire [15:0] lane_mask = 16'((32'h1 << lane_bits) - 32'h1);                      // RULE4
   wire [31:0] shifted   = shreg >> lane_bits;
   wire        period_end = o_busy & (cnt == DIV_M1);
   wire        last_beat  = beat == beats_m1;
   wire        take       = i_word_valid & (~o_busy | (period_end & last_beat));

   assign link.link_clk              = lclk;
   assign link.link_sync             = lsync;
   assign link.link_data             = ldata;
   assign link.injection_path_select = lsel;

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cnt          <= 8'h00;
         beat         <= 5'h00;
         shreg        <= '0;
         lclk         <= 1'b1;
         lsync        <= 1'b0;
         ldata        <= '0;
         lsel         <= 1'b0;
         o_busy       <= 1'b0;
         o_word_taken <= 1'b0;
      end else begin
         o_word_taken <= take;
         // select only changes between words
         if (!o_busy) begin
            lsel <= i_path_select; // RULE8
         end
         if (take) begin
            // data and sync settle while the clock is high
            o_busy <= 1'b1;
            cnt    <= 8'h00;
            beat   <= 5'h00;
            shreg  <= i_word;
            ldata  <= i_word[15:0] & lane_mask; // RULE4
            lsync  <= i_word_first;             // RULE7
            lclk   <= 1'b1;
         end else if (o_busy) begin
            cnt <= 8'(cnt + 8'h01);
            if (cnt == HALF_M1) begin
               lclk <= 1'b0; // RULE6
            end
            if (period_end) begin
               lclk  <= 1'b1;
               cnt   <= 8'h00;
               lsync <= 1'b0;
               if (last_beat) begin
                  o_busy <= 1'b0;
                  ldata  <= '0;
               end else begin
                  beat  <= 5'(beat + 5'h01);
                  shreg <= shifted;
                  ldata <= shifted[15:0] & lane_mask; // RULE6
               end
            end
         end
      end
   end

endmodule

// *** injection_link_assertions.sv ***
// checker for the wires between the injection source and receiver
`timescale 1ns/1ps
module injection_link_assertions (
   input wire logic                            i_clk,
   input wire logic                            i_rst_b,
   input wire logic                            link_clk,
   input wire logic                            link_sync,
   input wire logic [injection_pkg::LANES-1:0] link_data,
   input wire logic                            injection_path_select
);
   // beat lengths assume the source divider of 8
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_b);
   data_at_fall_a: assert property ($fell(link_clk) |-> $stable(link_data))
      else $error("lane data moved at link clock fall");
   data_moves_high_a: assert property ($changed(link_data) |-> link_clk)
      else $error("lane data moved while link clock low");
   sync_at_fall_a: assert property ($fell(link_clk) |-> $stable(link_sync))
      else $error("sync moved at link clock fall");
   sync_one_beat_a: assert property ($rose(link_sync) |-> link_sync [*8] ##1 !link_sync)
      else $error("sync not exactly one beat");
   sync_to_fall_a: assert property ($rose(link_sync) |-> link_clk ##4 $fell(link_clk))
      else $error("no falling edge inside sync beat");
   low_width_a: assert property ($fell(link_clk) |-> !link_clk [*4] ##1 link_clk)
      else $error("link clock low phase wrong");
   high_width_a: assert property ($rose(link_clk) |-> link_clk [*4])
      else $error("link clock high phase too short");
   select_idle_a: assert property ($changed(injection_path_select) |-> !link_sync)
      else $error("path select moved inside a packet");
   cover property ($rose(link_sync));
   cover property ($rose(injection_path_select));
   cover property ($fell(link_clk) && link_data[15]);
endmodule

// *** injection_link_tb.sv ***
// self-checking bench: source end streams words to the receiver end
`timescale 1ns/1ps
`define CHK(nm, got, exp) begin compares++; if ((got) !== (exp)) begin n_errors++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
module injection_link_tb;
   logic                       i_clk;
   logic                       i_rst_b = 1'b0;
   logic                       trace_mode = 1'b1;
   logic                       path_select = 1'b0;
   logic                       word_valid = 1'b0;
   logic                       word_first = 1'b0;
   logic                       bus_ack = 1'b0;
   injection_pkg::width_code_t width_code = injection_pkg::WIDTH_16;
   logic [31:0]                direct_base = 32'h0;
   logic [31:0]                word = 32'h0;
   logic                       word_taken, bus_req, cfg_valid, overrun, busy;
   logic [31:0]                bus_addr, bus_data, cfg_addr, cfg_word;
   int                         n_errors = 0;
   int                         compares = 0;
   injection_if lnk ();
   injection_src i_injection_src (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_width_code(width_code),
      .i_path_select(path_select), .i_word_valid(word_valid), .i_word_first(word_first),
      .i_word(word), .o_word_taken(word_taken), .o_busy(busy), .link(lnk.src));
   injection_rx i_injection_rx (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_trace_mode(trace_mode),
      .i_width_code(width_code), .i_direct_base(direct_base), .link(lnk.rx),
      .o_bus_req(bus_req), .o_bus_addr(bus_addr), .o_bus_data(bus_data), .i_bus_ack(bus_ack),
      .o_cfg_valid(cfg_valid), .o_cfg_addr(cfg_addr), .o_cfg_word(cfg_word), .o_overrun(overrun));
   injection_link_assertions i_injection_link_assertions (.i_clk(i_clk), .i_rst_b(i_rst_b),
      .link_clk(lnk.link_clk), .link_sync(lnk.link_sync), .link_data(lnk.link_data),
      .injection_path_select(lnk.injection_path_select));
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   task automatic complete_run();
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // valid is held until taken, so the source never sees a gap mid-offer
   task automatic send(input logic [31:0] w, input logic first);
      int n;
      n = 0;
      @(posedge i_clk);
      word_valid <= 1'b1;
      word <= w;
      word_first <= first;
      do begin
         @(negedge i_clk);
         n++;
      end while (word_taken !== 1'b1 && n < 4000);
      if (n >= 4000) begin n_errors++; complete_run(); end
      @(posedge i_clk);
      word_valid <= 1'b0;
   endtask
   task automatic expect_write(input logic cfg, input logic [31:0] a, input logic [31:0] d);
      int n;
      n = 0;
      do begin
         @(negedge i_clk);
         n++;
      end while ((cfg ? cfg_valid : bus_req) !== 1'b1 && n < 4000);
      if (n >= 4000) begin n_errors++; complete_run(); end
      `CHK("write address", cfg ? cfg_addr : bus_addr, a)
      `CHK("write data", cfg ? cfg_word : bus_data, d)
      if (!cfg) begin
         @(posedge i_clk);
         bus_ack <= 1'b1;
      end
      @(posedge i_clk);
      bus_ack <= 1'b0;
      @(negedge i_clk);
      `CHK("write strobe low", cfg ? cfg_valid : bus_req, 1'b0)
   endtask
   initial begin
      repeat (16) @(posedge i_clk);
      i_rst_b <= 1'b1;
      repeat (4) @(posedge i_clk);
      for (int k = 0; k < 5; k++) begin
         @(posedge i_clk);
         width_code <= 3'(k);
         send(32'hFFFF_FF00 | 32'(k), 1'b1);
         send(32'hA5C3_0F96 ^ 32'(k), 1'b0);
         expect_write(1'b0, 32'hFFFF_FF00 | 32'(k), 32'hA5C3_0F96 ^ 32'(k));
      end
      @(posedge i_clk);
      trace_mode <= 1'b0;
      width_code <= injection_pkg::WIDTH_8;
      direct_base <= 32'hFFFF_FFF8;
      send(32'h1111_0001, 1'b1);
      send(32'h2222_0002, 1'b0);
      expect_write(1'b0, 32'hFFFF_FFF8, 32'h1111_0001);
      send(32'h3333_0003, 1'b0);
      expect_write(1'b0, 32'hFFFF_FFFC, 32'h2222_0002);
      expect_write(1'b0, 32'h0000_0000, 32'h3333_0003);
      @(posedge i_clk);
      trace_mode <= 1'b1;
      path_select <= 1'b1;
      width_code <= injection_pkg::WIDTH_4;
      send(32'h0000_004C, 1'b1);
      @(negedge i_clk);
      `CHK("first beat lanes", lnk.link_data, 16'h000C)
      `CHK("sync on first beat", lnk.link_sync, 1'b1)
      `CHK("source busy", busy, 1'b1)
      send(32'hC0DE_5A5A, 1'b0);
      expect_write(1'b1, 32'h0000_004C, 32'hC0DE_5A5A);
      `CHK("no memory write", bus_req, 1'b0)
      `CHK("idle link clock", lnk.link_clk, 1'b1)
      `CHK("source idle", busy, 1'b0)
      // no buffer: an unacked write makes the next finished word drop
      @(posedge i_clk);
      path_select <= 1'b0;
      trace_mode <= 1'b0;
      width_code <= injection_pkg::WIDTH_16;
      direct_base <= 32'h0000_1000;
      send(32'h0BAD_0001, 1'b1);
      send(32'h0BAD_0002, 1'b0);
      send(32'h0BAD_0003, 1'b0);
      send(32'h0BAD_0004, 1'b0);
      @(negedge i_clk);
      `CHK("overrun flag", overrun, 1'b1)
      `CHK("held data", bus_data, 32'h0BAD_0001)
      @(posedge i_clk);
      i_rst_b <= 1'b0;
      repeat (2) @(posedge i_clk);
      @(negedge i_clk);
      `CHK("overrun cleared", overrun, 1'b0)
      complete_run();
   end
endmodule
